// ### hdl/mpm_pkg.sv
// shared constants and types for the memory page map unit
package mpm_pkg;
    // ==========================================================
    // i/o device codes and transfer kinds
    localparam logic [5:0] DEV_MAIN = 6'h02;
    localparam logic [5:0] DEV_AUX = 6'h03;
    localparam int DEV_W = 6;
    localparam int WORD_W = 16;
    localparam int PHYS_W = 7;
    localparam int OFFS_W = 10;
    localparam int LPAGE_W = 6;
    localparam int PADDR_W = PHYS_W + OFFS_W;
    localparam int ENTRIES = 64;
    localparam int NMAPS = 4;
    // map index encoding: 0 user A, 1 user B, 2 data channel A, 3 data channel B / utility
    localparam logic [1:0] MAP_UA = 2'h0;
    localparam logic [1:0] MAP_UB = 2'h1;
    localparam logic [1:0] MAP_DA = 2'h2;
    localparam logic [1:0] MAP_DB = 2'h3;
    // ==========================================================
    // word bit positions as vector indices; document bit 0, the most significant bit of a word, is index 15
    localparam int B_SEL = 15;
    localparam int B_LP_HI = 14;
    localparam int B_LP_LO = 10;
    localparam int B_AB = 9;
    localparam int B_PH_HI = 6;
    localparam int B_PM = 15;
    localparam int B_DCM = 14;
    localparam int B_PMI = 13;
    localparam int B_UME = 9;
    localparam int B_SCAB = 5;
    localparam int B_PAB = 0;
    localparam int SC_DELAY = 2;
    localparam logic [1:0] SC_CNT0 = 2'h0;
    // ==========================================================
    typedef enum logic [1:0] {XF_NONE, XF_A, XF_B, XF_C} mpm_xfer_t;
    typedef enum logic [1:0] {FL_NONE, FL_SET, FL_CLR, FL_PULSE} mpm_flag_t;
    typedef struct packed {
        logic valid;
        logic isOut;
        mpm_xfer_t xfer;
        mpm_flag_t flag;
        logic [DEV_W-1:0] dev;
        logic [WORD_W-1:0] acc;
    } mpm_io_t;
    typedef struct packed {
        logic valid;
        logic dataChan;
        logic indirect;
        logic [WORD_W-1:0] addr;
    } mpm_ref_t;
    typedef struct packed {
        logic progEn;
        logic progArmed;
        logic dataEn;
        logic inhibit;
        logic utilEn;
        logic scSel;
        logic progSel;
    } mpm_stat_t;
endpackage

// ### hdl/mpm_reset_sync.sv
// reset release synchroniser
`timescale 1ns/1ps
module mpm_reset_sync (
    input wire logic ref_clk,
    input wire logic rst_b,
    output logic rstSync_b
);
    logic meta_r;
    // two flops release the reset in step with the clock
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= 1'b0;
            rstSync_b <= 1'b0;
        end else begin
            meta_r <= 1'b1;
            rstSync_b <= meta_r;
        end
    end
endmodule // mpm_reset_sync

// ### hdl/mpm_pin_sync.sv
// three-flop synchroniser, output changes when stages two and three agree
`timescale 1ns/1ps
module mpm_pin_sync (
    input wire logic ref_clk,
    input wire logic rstSync_b,
    input wire logic pinIn,
    output logic pinOut
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic out_nxt;
    // agreement filter on the last two stages
    always_comb begin
        out_nxt = pinOut;
        if (s2_r == s3_r) begin
            out_nxt = s3_r;
        end
    end
    always_ff @(posedge ref_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            pinOut <= 1'b0;
        end else begin
            s1_r <= pinIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pinOut <= out_nxt;
        end
    end
endmodule // mpm_pin_sync

// ### hdl/mpm_map_unit.sv
// memory page map unit: map store, status, page check and address translation
`timescale 1ns/1ps
// Overview of operation
// (RL1) 32K mode: two user, two channel maps
// (RL2) 64K mode: two user, channel, utility maps
// (RL3) enabled stream translated, else passes straight through
// (RL4) status write bit 1 sets channel enable
// (RL5) status bit 0 arms; enable after indirect
// (RL6) interrupt request sets inhibit, stops user translation
// (RL7) inhibited interrupt runs on physical addresses
// (RL8) stack fault and trap inhibit likewise
// (RL9) map instructions talk only to CPU
// (RL10) answers device codes 2 and 3
// (RL11) pulse on code 2 maps second reference
// (RL12) clear on code 3 disables and initialises
// (RL13) unused flag commands have no function
// (RL14) load map writes entry, accumulator kept
// (RL15) load word: select, page, bank, physical
// (RL16) bit 6 picks A or B map
// (RL17) initiate check captures word and entry
// (RL18) check word: select, page, bank fields
// (RL19) page check returns captured bits, physical
// (RL20) physical page prefixed to page offset
// (RL21) high address bits index the entry
module mpm_map_unit
    import mpm_pkg::*;
#(
    parameter int ENTRY_CNT = mpm_pkg::ENTRIES
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic mode64k,
    input wire mpm_pkg::mpm_io_t ioReq,
    input wire mpm_pkg::mpm_ref_t memRef,
    input wire logic intReqPin,
    input wire logic stackFault,
    input wire logic trapTaken,
    output logic [mpm_pkg::WORD_W-1:0] ioData,
    output logic ioAck,
    output logic [mpm_pkg::PADDR_W-1:0] physAddr,
    output logic physValid,
    output logic mapped,
    output mpm_pkg::mpm_stat_t status
);
    import mpm_pkg::*;

    // ==========================================================
    // reset and pin synchronisation
    logic rstSync_b;
    logic intReq;
    logic intReqD_r;
    mpm_reset_sync uRst (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .rstSync_b(rstSync_b)
    );
    mpm_pin_sync uInt (
        .ref_clk(ref_clk),
        .rstSync_b(rstSync_b),
        .pinIn(intReqPin),
        .pinOut(intReq)
    );

    // ==========================================================
    // decode helpers
    function automatic logic isCmd(input mpm_io_t r, input logic [DEV_W-1:0] d, input logic o, input mpm_xfer_t x);
        isCmd = r.valid && (r.dev == d) && (r.isOut == o) && (r.xfer == x);
    endfunction
    // map index from family and bank bits; utility map shares the channel B slot
    function automatic logic [1:0] mapIdx(input logic fam, input logic bank);
        mapIdx = {fam, bank};
    endfunction
    function automatic logic [LPAGE_W-1:0] pageOf(input logic [WORD_W-1:0] a);
        pageOf = a[WORD_W-1 -: LPAGE_W];
    endfunction
    // status word as read back: program and channel enables and inhibit on top, utility enable and select bits low, reserved fields zero
    function automatic logic [WORD_W-1:0] statWord(input mpm_stat_t s);
        statWord = {s.progEn, s.dataEn, s.inhibit, 3'h0, s.utilEn, 2'h0, 1'b0, s.scSel, 4'h0, s.progSel};
    endfunction

    // RL9 RL10: only codes 2 and 3 are decoded, no peripheral traffic
    logic isLoad;
    logic isStatW;
    logic isStatR;
    logic isChkW;
    logic isChkR;
    logic isScPulse;
    logic isClear;
    logic isDevAny;
    assign isLoad = isCmd(ioReq, DEV_MAIN, 1'b1, XF_B); // RL14
    assign isStatW = isCmd(ioReq, DEV_MAIN, 1'b1, XF_A);
    assign isStatR = isCmd(ioReq, DEV_MAIN, 1'b0, XF_A);
    assign isChkW = isCmd(ioReq, DEV_AUX, 1'b1, XF_A); // RL17
    assign isChkR = isCmd(ioReq, DEV_AUX, 1'b0, XF_A); // RL19
    // set/clear on code 2 and set/pulse on code 3 fall through with no effect
    assign isScPulse = ioReq.valid && ioReq.dev == DEV_MAIN && ioReq.flag == FL_PULSE; // RL11
    assign isClear = ioReq.valid && ioReq.dev == DEV_AUX && ioReq.flag == FL_CLR; // RL12
    assign isDevAny = ioReq.valid && (ioReq.dev == DEV_MAIN || ioReq.dev == DEV_AUX); // RL10

    // ==========================================================
    // map store: four maps of 64 entries, flip-flops addressed by index
    logic [PHYS_W-1:0] map_r [NMAPS][ENTRY_CNT];
    logic [1:0] ldMap;
    logic [LPAGE_W-1:0] ldPage;
    // RL15 RL16: bit 0 family, bit 6 bank, bits 1-5 page (the extra top index bit is held 0, in 64K mode too)
    assign ldMap = mapIdx(ioReq.acc[B_SEL], ioReq.acc[B_AB]); // RL16
    assign ldPage = {1'b0, ioReq.acc[B_LP_HI:B_LP_LO]}; // RL15
    genvar gm;
    genvar ge;
    generate
        for (gm = 0; gm < NMAPS; gm++) begin : gMap
            for (ge = 0; ge < ENTRY_CNT; ge++) begin : gEnt
                logic [PHYS_W-1:0] ent_nxt;
                // a load writes only the entry named by family, bank and page
                always_comb begin
                    ent_nxt = map_r[gm][ge];
                    if (isLoad && ldMap == 2'(gm) && ldPage == LPAGE_W'(ge)) begin
                        ent_nxt = ioReq.acc[B_PH_HI:0]; // RL14 RL15
                    end
                end
                // entry register
                always_ff @(posedge ref_clk or negedge rstSync_b) begin
                    if (!rstSync_b) begin
                        map_r[gm][ge] <= '0;
                    end else begin
                        map_r[gm][ge] <= ent_nxt;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // status word: enables, arming, inhibit and select bits
    mpm_stat_t stat_r;
    mpm_stat_t stat_nxt;
    logic intEdge;
    logic nonDc;
    logic armStep;
    assign intEdge = intReq && !intReqD_r;
    assign nonDc = memRef.valid && !memRef.dataChan;
    // only a processor indirect reference completes the two-step program map enable
    assign armStep = stat_r.progArmed && nonDc && memRef.indirect; // RL5
    // write, arming step, inhibit entry and clear, later steps taking priority except that a write blocks the arming step
    always_comb begin
        stat_nxt = stat_r;
        if (isStatW) begin
            stat_nxt.dataEn = ioReq.acc[B_DCM]; // RL4
            stat_nxt.progArmed = ioReq.acc[B_PM]; // RL5
            stat_nxt.progEn = 1'b0;
            stat_nxt.inhibit = 1'b0;
            stat_nxt.utilEn = ioReq.acc[B_UME];
            stat_nxt.scSel = ioReq.acc[B_SCAB];
            stat_nxt.progSel = ioReq.acc[B_PAB];
        end else if (armStep) begin
            stat_nxt.progEn = 1'b1; // RL5
            stat_nxt.progArmed = 1'b0;
        end
        // interrupt, stack fault and trap entry all suspend user translation
        if (intEdge || stackFault || trapTaken) begin
            stat_nxt.inhibit = 1'b1; // RL6 RL7 RL8
        end
        if (isClear) begin
            stat_nxt = '0; // RL12
        end
    end
    // status registers and the interrupt edge detector
    always_ff @(posedge ref_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            stat_r <= '0;
            intReqD_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            intReqD_r <= intReq;
        end
    end

    // ==========================================================
    // single-cycle mapping countdown
    logic [1:0] scCnt_r;
    logic [1:0] scCnt_nxt;
    // channel cycles interleave freely, so only processor references are counted
    always_comb begin
        scCnt_nxt = scCnt_r;
        if (isScPulse) begin
            scCnt_nxt = 2'(SC_DELAY); // RL11
        end else if (nonDc && scCnt_r != SC_CNT0) begin
            scCnt_nxt = scCnt_r - 2'h1;
        end
        if (isClear) begin
            scCnt_nxt = SC_CNT0; // RL12
        end
    end
    always_ff @(posedge ref_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            scCnt_r <= SC_CNT0;
        end else begin
            scCnt_r <= scCnt_nxt;
        end
    end

    // ==========================================================
    // page-check capture: request bits and the entry they name, taken together
    logic [8:0] chk_r;
    logic [8:0] chk_nxt;
    logic [PHYS_W-1:0] chkPhys_r;
    logic [PHYS_W-1:0] chkPhys_nxt;
    // load and check words agree in bits 0-6, so the load field decode is shared
    always_comb begin
        chk_nxt = chk_r;
        chkPhys_nxt = chkPhys_r;
        if (isChkW) begin
            chk_nxt = ioReq.acc[WORD_W-1 -: 9]; // RL17 RL18
            chkPhys_nxt = map_r[ldMap][ldPage]; // RL17
        end
        if (isClear) begin
            chk_nxt = '0; // RL12
            chkPhys_nxt = '0;
        end
    end
    always_ff @(posedge ref_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            chk_r <= '0;
            chkPhys_r <= '0;
        end else begin
            chk_r <= chk_nxt;
            chkPhys_r <= chkPhys_nxt;
        end
    end

    // ==========================================================
    // i/o answer: read data and acknowledge, one cycle after the request
    logic [WORD_W-1:0] ioData_nxt;
    logic ioAck_nxt;
    // reserved and unimplemented fields read as zero
    always_comb begin
        ioData_nxt = '0;
        ioAck_nxt = isDevAny; // RL9 RL10
        if (isChkR) begin
            ioData_nxt = {chk_r[8:2], 2'b00, chkPhys_r}; // RL19
        end else if (isStatR) begin
            ioData_nxt = statWord(stat_r);
        end
    end
    always_ff @(posedge ref_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            ioData <= '0;
            ioAck <= 1'b0;
        end else begin
            ioData <= ioData_nxt;
            ioAck <= ioAck_nxt;
        end
    end

    // ==========================================================
    // address translation, registered one cycle after the reference
    logic [1:0] xMap;
    logic xOn;
    logic [LPAGE_W-1:0] xPage;
    logic [PADDR_W-1:0] phys_nxt;
    logic scHit;
    assign scHit = nonDc && scCnt_r == 2'h1;
    always_comb begin
        xMap = MAP_UA;
        xOn = 1'b0;
        // RL21: 32K mode uses address bits 1-5, 64K mode bits 0-5
        xPage = mode64k ? pageOf(memRef.addr) : {1'b0, memRef.addr[WORD_W-2 -: 5]};
        if (memRef.dataChan) begin
            xMap = mode64k ? MAP_DA : mapIdx(1'b1, stat_r.progSel); // RL1 RL2
            xOn = stat_r.dataEn; // RL3
        end else if (scHit) begin
            xMap = mapIdx(1'b0, stat_r.scSel); // RL11
            xOn = 1'b1;
        end else if (stat_r.utilEn && mode64k) begin
            xMap = MAP_DB; // RL2
            xOn = !stat_r.inhibit;
        end else begin
            xMap = mapIdx(1'b0, stat_r.progSel);
            xOn = stat_r.progEn && !stat_r.inhibit; // RL3 RL6
        end
        if (xOn) begin
            phys_nxt = {map_r[xMap][xPage], memRef.addr[OFFS_W-1:0]}; // RL20
        end else if (mode64k) begin
            phys_nxt = {1'b0, memRef.addr}; // RL3
        end else begin
            phys_nxt = {2'h0, memRef.addr[WORD_W-2:0]}; // RL3
        end
    end
    // translated address, qualifiers and the status copy leave from flops
    always_ff @(posedge ref_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            physAddr <= '0;
            physValid <= 1'b0;
            mapped <= 1'b0;
            status <= '0;
        end else begin
            physAddr <= phys_nxt;
            physValid <= memRef.valid;
            mapped <= memRef.valid && xOn;
            status <= stat_nxt;
        end
    end
endmodule // mpm_map_unit

// ### verification/mpm_map_unit_sva.sv
// port-level assertion checker for the memory page map unit
`timescale 1ns/1ps
module mpm_map_unit_chk
    import mpm_pkg::*;
#(
    parameter int ENTRY_CNT = 64
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire mpm_pkg::mpm_io_t ioReq,
    input wire mpm_pkg::mpm_ref_t memRef,
    input wire logic stackFault,
    input wire logic trapTaken,
    input wire logic ioAck,
    input wire logic [mpm_pkg::PADDR_W-1:0] physAddr,
    input wire logic physValid,
    input wire logic mapped,
    input wire mpm_pkg::mpm_stat_t status
);
    logic ourDev;
    logic statWr;
    logic clrMap;
    logic scPulse;
    logic nonDcRef;
    logic [1:0] scLeft_r;
    logic [1:0] scLeft_nxt;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // decoded requests
    assign ourDev = ioReq.valid && (ioReq.dev == DEV_MAIN || ioReq.dev == DEV_AUX);
    assign statWr = ioReq.valid && ioReq.isOut && ioReq.xfer == XF_A && ioReq.dev == DEV_MAIN;
    assign clrMap = ioReq.valid && ioReq.flag == FL_CLR && ioReq.dev == DEV_AUX;
    assign scPulse = ioReq.valid && ioReq.flag == FL_PULSE && ioReq.dev == DEV_MAIN;
    assign nonDcRef = memRef.valid && !memRef.dataChan;
    // single-cycle countdown kept from the requests: the second processor reference is mapped
    always_comb begin
        scLeft_nxt = scLeft_r;
        if (scPulse) begin
            scLeft_nxt = 2'h2;
        end else if (nonDcRef && scLeft_r != 2'h0) begin
            scLeft_nxt = scLeft_r - 2'h1;
        end
        if (clrMap) begin
            scLeft_nxt = 2'h0;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            scLeft_r <= 2'h0;
        end else begin
            scLeft_r <= scLeft_nxt;
        end
    end
    sequence seqScTurn;
        nonDcRef && scLeft_r == 2'h1;
    endsequence
    // program map arming takes two steps
    sequence seqArm;
        statWr && ioReq.acc[15] && !status.progEn && !(memRef.valid && memRef.indirect);
    endsequence
    sequence seqIndir;
        status.progArmed && memRef.valid && memRef.indirect && !memRef.dataChan && !ioReq.valid;
    endsequence
    chk_ack_own: assert property (ourDev |=> ioAck)
        else $error("map request not acknowledged");
    chk_ack_foreign: assert property (!ourDev |=> !ioAck)
        else $error("acknowledge without map request");
    chk_ref_offset: assert property (memRef.valid |=> physValid && physAddr[9:0] == $past(memRef.addr[9:0]))
        else $error("page offset not carried through");
    chk_untrans_pass: assert property (memRef.valid |=> mapped || physAddr[14:0] == $past(memRef.addr[14:0]))
        else $error("untranslated address altered");
    chk_dc_enable: assert property (statWr |=> status.dataEn == $past(ioReq.acc[14]))
        else $error("channel enable does not follow status write");
    chk_arm_wait: assert property (seqArm |=> status.progArmed && !status.progEn)
        else $error("program map enabled before indirect reference");
    chk_arm_enable: assert property (seqIndir |=> status.progEn)
        else $error("program map not enabled after indirect reference");
    chk_inhibit_set: assert property ((stackFault || trapTaken) && !clrMap |=> status.inhibit)
        else $error("fault or trap did not inhibit program map");
    chk_inhibit_stop: assert property (memRef.valid && !memRef.dataChan && status.inhibit && !status.utilEn
        && !ioReq.valid && scLeft_r != 2'h1 |=> !mapped)
        else $error("program reference translated while inhibited");
    chk_sc_mapped: assert property (seqScTurn |=> mapped)
        else $error("single-cycle reference not translated");
    chk_clear_all: assert property (clrMap |=> !status.progEn && !status.dataEn && !status.progArmed
        && !status.inhibit)
        else $error("clear command left map enabled");
endmodule // mpm_map_unit_chk

bind mpm_map_unit mpm_map_unit_chk #(.ENTRY_CNT(ENTRY_CNT)) uChk (.ref_clk(ref_clk), .rst_b(rst_b),
    .ioReq(ioReq), .memRef(memRef), .stackFault(stackFault), .trapTaken(trapTaken), .ioAck(ioAck),
    .physAddr(physAddr), .physValid(physValid), .mapped(mapped), .status(status));

// ### verification/mpm_cpu_model.sv
// behavioural cpu core issuing map instructions and memory references
`timescale 1ns/1ps
module mpm_cpu_model
    import mpm_pkg::*;
(
    input wire logic ref_clk,
    output mpm_pkg::mpm_io_t ioReq,
    output mpm_pkg::mpm_ref_t memRef,
    output logic intReqPin,
    output logic stackFault,
    output logic trapTaken,
    input wire logic [mpm_pkg::WORD_W-1:0] ioData,
    input wire logic ioAck,
    input wire logic [mpm_pkg::PADDR_W-1:0] physAddr,
    input wire logic physValid,
    input wire logic mapped
);
    // ==========================================================
    // idle bus at time zero
    initial begin
        ioReq = '0;
        memRef = '0;
        {intReqPin, stackFault, trapTaken} = 3'h0;
    end
    // one i/o instruction, answer looked for over three cycles
    task automatic io(input logic o, input mpm_xfer_t x, input mpm_flag_t f, input logic [5:0] dv,
        input logic [15:0] a, output logic [15:0] dat, output logic ack);
        ack = 1'b0;
        dat = 16'h0;
        @(negedge ref_clk);
        ioReq = '{1'b1, o, x, f, dv, a};
        @(negedge ref_clk);
        ioReq = '{1'b0, o, XF_NONE, FL_NONE, dv, ~a}; // released word scrambled
        for (int i = 0; i < 3 && !ack; i++) begin
            if (ioAck === 1'b1) begin
                ack = 1'b1;
                dat = ioData;
            end else @(negedge ref_clk);
        end
    endtask
    // one memory reference, translated answer looked for over three cycles
    task automatic mref(input logic dc, input logic ind, input logic [15:0] a, output logic [16:0] pa,
        output logic mp);
        pa = 17'h1ffff;
        mp = 1'bx;
        @(negedge ref_clk);
        memRef = '{1'b1, dc, ind, a};
        @(negedge ref_clk);
        memRef = '{1'b0, dc, 1'b0, ~a};
        for (int i = 0; i < 3 && pa === 17'h1ffff; i++) begin
            if (physValid === 1'b1) begin
                pa = physAddr;
                mp = mapped;
            end else @(negedge ref_clk);
        end
    endtask
    // one-cycle fault (0) or trap (1) pulse
    task automatic pulse(input int kind);
        @(negedge ref_clk);
        stackFault = (kind == 0);
        trapTaken = (kind == 1);
        @(negedge ref_clk);
        {stackFault, trapTaken} = 2'h0;
    endtask
    // interrupt request pin level
    task automatic irq(input logic v);
        @(negedge ref_clk);
        intReqPin = v;
    endtask
endmodule // mpm_cpu_model

// ### verification/tb.sv
// self-checking testbench for the memory page map unit
`timescale 1ns/1ps
module tb;
    import mpm_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic mode64k = 1'b0;
    mpm_io_t ioReq;
    mpm_ref_t memRef;
    logic intReqPin, stackFault, trapTaken, ioAck, physValid, mapped, k, mp;
    logic [15:0] ioData, d;
    logic [16:0] physAddr, pa;
    mpm_stat_t status;
    int badCount = 0;
    int checkCount = 0;
    int n;
    logic [15:0] lw [3] = '{16'h142a, 16'h1633, 16'h8c11};
    mpm_flag_t fl [4] = '{FL_SET, FL_CLR, FL_SET, FL_PULSE};
    logic [5:0] dv [4] = '{DEV_MAIN, DEV_MAIN, DEV_AUX, DEV_AUX};
    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;
    mpm_map_unit dut (.ref_clk, .rst_b, .mode64k, .ioReq, .memRef, .intReqPin, .stackFault, .trapTaken,
        .ioData, .ioAck, .physAddr, .physValid, .mapped, .status);
    mpm_cpu_model cpu (.ref_clk, .ioReq, .memRef, .intReqPin, .stackFault, .trapTaken, .ioData, .ioAck,
        .physAddr, .physValid, .mapped);
    // ==========================================================
    // compare, report and close
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        checkCount++;
        if (got !== exp) begin
            badCount++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finishTest;
        $display("checks %0d mismatches %0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic stw(input logic [15:0] a);
        cpu.io(1'b1, XF_A, FL_NONE, DEV_MAIN, a, d, k);
    endtask
    task automatic r(input logic dc, input logic ind, input logic [15:0] a, input logic [16:0] e,
        input logic m);
        cpu.mref(dc, ind, a, pa, mp);
        chk(pa, e);
        chk(mp, m);
    endtask
    // main sequence
    initial begin
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(status, 17'h0);
        foreach (lw[i]) begin
            cpu.io(1'b1, XF_B, FL_NONE, DEV_MAIN, lw[i], d, k);
            chk(k, 1'b1);
        end
        foreach (lw[i]) begin
            cpu.io(1'b1, XF_A, FL_NONE, DEV_AUX, lw[i] & 16'hfe00, d, k);
            cpu.io(1'b0, XF_A, FL_NONE, DEV_AUX, 16'h0, d, k);
            chk(d, lw[i]);
        end
        r(1'b1, 1'b0, 16'h0c55, 17'h00c55, 1'b0);
        stw(16'h4000);
        chk(status.dataEn, 1'b1);
        r(1'b1, 1'b0, 16'h8c55, 17'h04455, 1'b1);
        stw(16'hc000);
        r(1'b0, 1'b0, 16'h1403, 17'h01403, 1'b0);
        cpu.mref(1'b0, 1'b1, 16'h0100, pa, mp);
        r(1'b0, 1'b0, 16'h1403, 17'h0a803, 1'b1);
        cpu.pulse(1);
        chk(status.inhibit, 1'b1);
        r(1'b0, 1'b0, 16'h1403, 17'h01403, 1'b0);
        stw(16'hc000);
        cpu.pulse(0);
        chk(status.inhibit, 1'b1);
        stw(16'hc000);
        cpu.irq(1'b1);
        for (n = 0; n < 8 && status.inhibit !== 1'b1; n++) @(negedge ref_clk);
        chk(status.inhibit, 1'b1);
        cpu.irq(1'b0);
        foreach (fl[i]) begin
            cpu.io(1'b0, XF_NONE, fl[i], dv[i], 16'h0, d, k);
            chk({k, status.dataEn}, 2'h3);
        end
        cpu.io(1'b1, XF_A, FL_NONE, 6'h05, 16'h0, d, k);
        chk({k, status.dataEn}, 2'h1);
        cpu.io(1'b0, XF_NONE, FL_CLR, DEV_AUX, 16'h0, d, k);
        chk({status.progEn, status.dataEn, status.progArmed}, 3'h0);
        r(1'b1, 1'b0, 16'h0c55, 17'h00c55, 1'b0);
        cpu.io(1'b0, XF_NONE, FL_PULSE, DEV_MAIN, 16'h0, d, k);
        r(1'b1, 1'b0, 16'h0c55, 17'h00c55, 1'b0);
        r(1'b0, 1'b0, 16'h1403, 17'h01403, 1'b0);
        r(1'b0, 1'b0, 16'h1403, 17'h0a803, 1'b1);
        r(1'b0, 1'b0, 16'h1403, 17'h01403, 1'b0);
        // 64K mode: one channel map whatever the program select, utility map, wide pass-through
        mode64k = 1'b1;
        cpu.io(1'b1, XF_B, FL_NONE, DEV_MAIN, 16'h8a45, d, k);
        cpu.io(1'b1, XF_A, FL_NONE, DEV_AUX, 16'h8a00, d, k);
        cpu.io(1'b0, XF_A, FL_NONE, DEV_AUX, 16'h0, d, k);
        chk(d, 16'h8a45);
        stw(16'h4201);
        cpu.io(1'b0, XF_A, FL_NONE, DEV_MAIN, 16'h0, d, k);
        chk(d, 16'h4201);
        r(1'b1, 1'b0, 16'h0c55, 17'h04455, 1'b1);
        r(1'b0, 1'b0, 16'h0803, 17'h11403, 1'b1);
        stw(16'h0000);
        r(1'b1, 1'b0, 16'h8c55, 17'h08c55, 1'b0);
        r(1'b0, 1'b0, 16'h8803, 17'h08803, 1'b0);
        finishTest();
    end
    // watchdog against a hang
    initial begin
        #100000;
        badCount++;
        finishTest();
    end
endmodule // tb
